// [verilog/pabe_pkg.sv]
// Constants for the address/data and bus-control port block.
// Assumes an APB master with 32-bit data; each register takes one aligned word.
package pabe_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_A_DATA = 4'h0;
  localparam logic [3:0] IDX_B_DATA = 4'h1;
  localparam logic [3:0] IDX_A_DIR = 4'h2;
  localparam logic [3:0] IDX_B_DIR = 4'h3;
  localparam logic [3:0] IDX_E_DATA = 4'h8;
  localparam logic [3:0] IDX_E_DIR = 4'h9;
  localparam logic [3:0] IDX_BUS_CTRL_PIN_ASSIGNMENT = 4'ha;
  localparam logic [3:0] IDX_MODE = 4'hb;
  // Bit positions in the pin assignment register.
  localparam int B_NO_DATA_ENABLE_BIT = 7;
  localparam int B_PIPE_OUTPUT_ENABLE = 5;
  localparam int B_NO_E_CLOCK_BIT = 4;
  localparam int B_LOW_STROBE_ENABLE = 3;
  localparam int B_READ_WRITE_ENABLE = 2;
  // Bit positions in the mode control register.
  localparam int B_INTERNAL_VISIBILITY = 3;
  localparam int B_EME = 1;
  localparam int B_E_STRETCH = 0;
  // Implemented bits and reset values.
  localparam logic [7:0] BUS_CTRL_PIN_ASSIGNMENT_MASK = 8'hbc;
  localparam logic [7:0] E_DIR_MASK = 8'hfc;
  localparam logic [7:0] MODE_MASK = 8'h0b;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BUS_CTRL_PIN_ASSIGNMENT_RST_NEXP = 8'h00;
  localparam logic [7:0] BUS_CTRL_PIN_ASSIGNMENT_RST_SPEC = 8'h2c;
  localparam logic [7:0] BUS_CTRL_PIN_ASSIGNMENT_RST_QUIET = 8'h90;
  localparam logic [7:0] PE_PULL_PINS = 8'h8f;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Operating mode strap encoding.
  localparam logic [2:0] OPM_SPEC_SINGLE = 3'h0;
  localparam logic [2:0] OPM_SPEC_NARROW = 3'h1;
  localparam logic [2:0] OPM_PERIPH = 3'h2;
  localparam logic [2:0] OPM_SPEC_WIDE = 3'h3;
  localparam logic [2:0] OPM_NORM_SINGLE = 3'h4;
  localparam logic [2:0] OPM_NORM_NARROW = 3'h5;
  localparam logic [2:0] OPM_NORM_WIDE = 3'h7;
  // Start-up sequencer, Gray coded along its only path.
  typedef enum logic [1:0] {
    ST_SYNC1 = 2'b00,
    ST_SYNC2 = 2'b01,
    ST_LOAD = 2'b11,
    ST_RUN = 2'b10
  } pabe_state_type;
endpackage

// [verilog/pabe_top.sv]
// Port A, port B and port E general-purpose I/O with the port E assignment logic.
// Assumes pins are asynchronous to CORE_CLK and the bus interface signals are on it.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module pabe_top
  import pabe_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CORE_CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic [2:0] OP_MODE,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic BUS_ADDR_PHASE,
  input wire logic BUS_DATA_OE,
  input wire logic BUS_PHASE_CLK,
  input wire logic BUS_RW,
  input wire logic LOW_BYTE_STROBE_N,
  input wire logic DATA_BUS_ENABLE_N,
  input wire logic [1:0] QUEUE_PIPE,
  input wire logic PULL_EN_E,
  output logic [15:0] BUS_RDATA,
  output logic TAG_LOW_INPUT_N,
  output logic IRQ_N_LVL,
  output logic NONMASKABLE_INTERRUPT_PIN_N,
  input wire logic [7:0] PA_IN,
  output logic [7:0] PA_OUT,
  output logic [7:0] PA_OE,
  input wire logic [7:0] PB_IN,
  output logic [7:0] PB_OUT,
  output logic [7:0] PB_OE,
  input wire logic [7:0] PE_IN,
  output logic [7:0] PE_OUT,
  output logic [7:0] PE_OE,
  output logic [7:0] PE_PULL
);
  // Pin and strap synchronisers; stage one feeds stage two only.
  logic [26:0] sync1_ff;
  logic [26:0] sync2_ff;
  logic [7:0] pa_pin;
  logic [7:0] pb_pin;
  logic [7:0] pe_pin;
  logic [2:0] mode_pin;
  // Start-up sequencer and the latched operating mode.
  pabe_state_type state_ff;
  pabe_state_type nxt_state;
  logic [2:0] opm_ff;
  // Software visible registers.
  logic [7:0] a_data_ff;
  logic [7:0] b_data_ff;
  logic [7:0] a_dir_ff;
  logic [7:0] b_dir_ff;
  logic [7:0] e_data_ff;
  logic [7:0] e_dir_ff;
  logic [7:0] bus_ctrl_pin_assignment_ff;
  logic [7:0] mode_ff;
  logic bus_ctrl_pin_assignment_seen_ff;
  // Bus slave state.
  logic ready_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  // Decoded modes.
  logic is_single;
  logic is_periph;
  logic is_exp;
  logic is_narrow;
  logic is_special;
  logic run;
  // Access decode.
  logic acc;
  logic done;
  logic wr;
  logic [3:0] idx;
  logic hit;
  logic ab_vis;
  logic e_vis;
  logic [31:0] rd_word;
  // Port E alternate selection and pin drive.
  logic [7:0] e_alt;
  logic [7:0] e_alt_out;
  logic [7:0] e_gpio_oe;
  logic [7:0] bus_ctrl_pin_assignment_wmask;
  logic [7:0] nxt_bus_ctrl_pin_assignment;

  // Two flip-flops on every asynchronous input before anything reads it.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (CORE_CE) begin
      sync1_ff <= {OP_MODE, PE_IN, PB_IN, PA_IN};
      sync2_ff <= sync1_ff;
    end
  end
  assign pa_pin = sync2_ff[7:0];
  assign pb_pin = sync2_ff[15:8];
  assign pe_pin = sync2_ff[23:16];
  assign mode_pin = sync2_ff[26:24];

  // The sequencer waits for the strap to pass the synchroniser before loading.
  always_comb begin
    case (state_ff)
      ST_SYNC1: nxt_state = ST_SYNC2;
      ST_SYNC2: nxt_state = ST_LOAD;
      ST_LOAD: nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_SYNC1;
    endcase
  end

  // State register; a constant under reset, strap caught after release.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_SYNC1;
      opm_ff <= OPM_NORM_SINGLE;
    end else if (CORE_CE) begin
      state_ff <= nxt_state;
      if (state_ff == ST_LOAD) begin
        opm_ff <= mode_pin;
      end
    end
  end
  assign run = (state_ff == ST_RUN);

  // Mode decode; the unused code behaves as normal single-chip.
  assign is_periph = (opm_ff == OPM_PERIPH);
  assign is_single = (opm_ff == OPM_SPEC_SINGLE) || (opm_ff == OPM_NORM_SINGLE) ||
                     (opm_ff == 3'h6);
  assign is_exp = !is_single && !is_periph;
  assign is_narrow = (opm_ff == OPM_SPEC_NARROW) || (opm_ff == OPM_NORM_NARROW);
  assign is_special = !opm_ff[2];

  // Register visibility by mode.
  assign ab_vis = is_single;
  assign e_vis = !is_periph && !(is_exp && mode_ff[B_EME]);
  assign acc = PSEL && PENABLE && run;
  assign done = acc && ready_ff;
  assign wr = done && PWRITE && !slverr_ff;
  assign idx = PADDR[5:2];

  // Address decode; a hidden register answers as unmapped.
  always_comb begin
    hit = 1'b0;
    if (PADDR[11:6] == 6'h00 && PADDR[1:0] == 2'b00) begin
      case (idx)
        IDX_A_DATA, IDX_B_DATA, IDX_A_DIR, IDX_B_DIR: hit = ab_vis;
        IDX_E_DATA, IDX_E_DIR: hit = e_vis;
        IDX_BUS_CTRL_PIN_ASSIGNMENT: hit = !is_periph;
        IDX_MODE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // Read mux; data ports show pins for inputs and latches for outputs.
  always_comb begin
    rd_word = '0;
    case (idx)
      IDX_A_DATA: rd_word[7:0] = (a_dir_ff & a_data_ff) | (~a_dir_ff & pa_pin);
      IDX_B_DATA: rd_word[7:0] = (b_dir_ff & b_data_ff) | (~b_dir_ff & pb_pin);
      IDX_A_DIR: rd_word[7:0] = a_dir_ff;
      IDX_B_DIR: rd_word[7:0] = b_dir_ff;
      IDX_E_DATA: rd_word[7:0] = (e_gpio_oe & e_data_ff) | (~e_gpio_oe & pe_pin);
      IDX_E_DIR: rd_word[7:0] = e_dir_ff & E_DIR_MASK;
      IDX_BUS_CTRL_PIN_ASSIGNMENT: rd_word[15:0] = {mode_ff, bus_ctrl_pin_assignment_ff & BUS_CTRL_PIN_ASSIGNMENT_MASK};
      IDX_MODE: rd_word[7:0] = mode_ff;
      default: rd_word = '0;
    endcase
  end

  // APB answer: one wait state, so PREADY rises in the second access cycle.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ready_ff <= 1'b0;
      rdata_ff <= '0;
      slverr_ff <= 1'b0;
    end else if (CORE_CE) begin
      ready_ff <= acc && !ready_ff;
      if (acc && !ready_ff) begin
        rdata_ff <= (hit && !PWRITE) ? rd_word : '0;
        slverr_ff <= !hit;
      end else if (done) begin
        rdata_ff <= '0;
        slverr_ff <= 1'b0;
      end
    end
  end
  assign PREADY = ready_ff;
  assign PRDATA = rdata_ff;
  assign PSLVERR = slverr_ff;

  // Port A and B registers; direction registers reset to all inputs.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_data_ff <= BYTE_ZERO;
      b_data_ff <= BYTE_ZERO;
      a_dir_ff <= BYTE_ZERO;
      b_dir_ff <= BYTE_ZERO;
    end else if (CORE_CE && wr && PSTRB[0]) begin
      case (idx)
        IDX_A_DATA: a_data_ff <= PWDATA[7:0];
        IDX_B_DATA: b_data_ff <= PWDATA[7:0];
        IDX_A_DIR: a_dir_ff <= PWDATA[7:0];
        IDX_B_DIR: b_dir_ff <= PWDATA[7:0];
        default: a_data_ff <= a_data_ff;
      endcase
    end
  end

  // Port E data and direction; bits 1..0 of direction never store a one.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      e_data_ff <= BYTE_ZERO;
      e_dir_ff <= BYTE_ZERO;
    end else if (CORE_CE && wr && PSTRB[0]) begin
      if (idx == IDX_E_DATA) begin
        e_data_ff <= PWDATA[7:0];
      end
      if (idx == IDX_E_DIR) begin
        e_dir_ff <= PWDATA[7:0] & E_DIR_MASK;
      end
    end
  end

  // Write-once gating. Normal modes take only the first write of the guarded
  // bits, special modes every write but the first (bit 4 is written only in single-chip modes, every write in
  // special single-chip), which guards the bus setup that a monitor relies on right after reset.
  always_comb begin
    bus_ctrl_pin_assignment_wmask = (8'h01 << B_NO_DATA_ENABLE_BIT);
    if (is_special ? bus_ctrl_pin_assignment_seen_ff : !bus_ctrl_pin_assignment_seen_ff) begin
      bus_ctrl_pin_assignment_wmask = bus_ctrl_pin_assignment_wmask | (8'h01 << B_PIPE_OUTPUT_ENABLE) | (8'h01 << B_LOW_STROBE_ENABLE) |
                   (8'h01 << B_READ_WRITE_ENABLE);
    end
    if (is_single && (opm_ff == OPM_SPEC_SINGLE || !bus_ctrl_pin_assignment_seen_ff)) begin
      bus_ctrl_pin_assignment_wmask = bus_ctrl_pin_assignment_wmask | (8'h01 << B_NO_E_CLOCK_BIT);
    end
    nxt_bus_ctrl_pin_assignment = ((bus_ctrl_pin_assignment_ff & ~bus_ctrl_pin_assignment_wmask) | (PWDATA[7:0] & bus_ctrl_pin_assignment_wmask)) & BUS_CTRL_PIN_ASSIGNMENT_MASK;
  end

  // Assignment register; the mode-dependent value is loaded once the strap is in.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_ctrl_pin_assignment_ff <= BUS_CTRL_PIN_ASSIGNMENT_RST_QUIET;
      bus_ctrl_pin_assignment_seen_ff <= 1'b0;
    end else if (CORE_CE) begin
      if (state_ff == ST_LOAD) begin
        case (mode_pin)
          OPM_NORM_NARROW, OPM_NORM_WIDE: bus_ctrl_pin_assignment_ff <= BUS_CTRL_PIN_ASSIGNMENT_RST_NEXP;
          OPM_SPEC_SINGLE, OPM_SPEC_NARROW, OPM_SPEC_WIDE: bus_ctrl_pin_assignment_ff <= BUS_CTRL_PIN_ASSIGNMENT_RST_SPEC;
          default: bus_ctrl_pin_assignment_ff <= BUS_CTRL_PIN_ASSIGNMENT_RST_QUIET;
        endcase
      end else if (wr && idx == IDX_BUS_CTRL_PIN_ASSIGNMENT && PSTRB[0]) begin
        bus_ctrl_pin_assignment_ff <= nxt_bus_ctrl_pin_assignment;
        bus_ctrl_pin_assignment_seen_ff <= 1'b1;
      end
    end
  end

  // Mode control bits; a 16-bit write at the assignment word sets both bytes.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_ff <= MODE_RST;
    end else if (CORE_CE && wr) begin
      if (idx == IDX_BUS_CTRL_PIN_ASSIGNMENT && PSTRB[1]) begin
        mode_ff <= PWDATA[15:8] & MODE_MASK;
      end else if (idx == IDX_MODE && PSTRB[0]) begin
        mode_ff <= PWDATA[7:0] & MODE_MASK;
      end
    end
  end

  // Which port E pins take their alternate function.
  always_comb begin
    e_alt = BYTE_ZERO;
    e_alt[7] = !bus_ctrl_pin_assignment_ff[B_NO_DATA_ENABLE_BIT];
    e_alt[6] = bus_ctrl_pin_assignment_ff[B_PIPE_OUTPUT_ENABLE] && !is_single;
    e_alt[5] = bus_ctrl_pin_assignment_ff[B_PIPE_OUTPUT_ENABLE] && !is_single;
    e_alt[4] = !bus_ctrl_pin_assignment_ff[B_NO_E_CLOCK_BIT] &&
               (!is_single || mode_ff[B_INTERNAL_VISIBILITY] || !mode_ff[B_E_STRETCH]);
    e_alt[3] = bus_ctrl_pin_assignment_ff[B_LOW_STROBE_ENABLE] && !is_single &&
               !(is_narrow && !is_special);
    e_alt[2] = bus_ctrl_pin_assignment_ff[B_READ_WRITE_ENABLE] && !is_single;
    e_alt_out = {DATA_BUS_ENABLE_N, QUEUE_PIPE, BUS_PHASE_CLK, LOW_BYTE_STROBE_N,
                 BUS_RW, 2'b00};
    e_gpio_oe = e_dir_ff & E_DIR_MASK & ~e_alt;
  end

  // Registered pin drive for all three ports.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PA_OUT <= BYTE_ZERO;
      PA_OE <= BYTE_ZERO;
      PB_OUT <= BYTE_ZERO;
      PB_OE <= BYTE_ZERO;
      PE_OUT <= BYTE_ZERO;
      PE_OE <= BYTE_ZERO;
      PE_PULL <= BYTE_ZERO;
    end else if (CORE_CE) begin
      if (is_single) begin
        PA_OUT <= a_data_ff;
        PA_OE <= a_dir_ff;
        PB_OUT <= b_data_ff;
        PB_OE <= b_dir_ff;
      end else begin
        // Address phase drives address; data phase drives data when writing, but narrow modes keep the address on port B.
        PA_OUT <= BUS_ADDR_PHASE ? BUS_ADDR[15:8] : BUS_WDATA[15:8];
        PA_OE <= {8{BUS_ADDR_PHASE || BUS_DATA_OE}};
        if (is_narrow) begin
          PB_OUT <= BUS_ADDR[7:0];
          PB_OE <= 8'hff;
        end else begin
          PB_OUT <= BUS_ADDR_PHASE ? BUS_ADDR[7:0] : BUS_WDATA[7:0];
          PB_OE <= {8{BUS_ADDR_PHASE || BUS_DATA_OE}};
        end
      end
      PE_OUT <= (e_alt & e_alt_out) | (~e_alt & e_data_ff);
      PE_OE <= e_alt | e_gpio_oe;
      PE_PULL <= {8{PULL_EN_E}} & PE_PULL_PINS & ~(e_alt | e_gpio_oe);
    end
  end

  // Pin levels back to the core; tag input is meaningful only with the strobe on.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_RDATA <= '0;
      TAG_LOW_INPUT_N <= 1'b1;
      IRQ_N_LVL <= 1'b1;
      NONMASKABLE_INTERRUPT_PIN_N <= 1'b1;
    end else if (CORE_CE) begin
      BUS_RDATA <= {pa_pin, pb_pin};
      TAG_LOW_INPUT_N <= !(is_special && is_exp && bus_ctrl_pin_assignment_ff[B_LOW_STROBE_ENABLE]) || pe_pin[3];
      IRQ_N_LVL <= pe_pin[1];
      NONMASKABLE_INTERRUPT_PIN_N <= pe_pin[0];
    end
  end

  // Checks.
  a_pe10_input_only: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    PE_OE[1:0] == 2'b00) else $error("port E bits 1..0 driven");
  a_dbe_pin_drive: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && !bus_ctrl_pin_assignment_ff[B_NO_DATA_ENABLE_BIT] |=> PE_OE[7]) else $error("pin 7 not data enable");
  a_pipe_pins_out: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && bus_ctrl_pin_assignment_ff[B_PIPE_OUTPUT_ENABLE] && !is_single |=> PE_OE[6:5] == 2'b11)
    else $error("pipe pins not driven");
  a_rw_single_gpio: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && is_single && !e_dir_ff[2] |=> !PE_OE[2])
    else $error("read/write pin driven in single-chip");
  a_strobe_norm_narrow: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && opm_ff == OPM_NORM_NARROW && !e_dir_ff[3] |=> !PE_OE[3])
    else $error("strobe pin driven in normal narrow");
  a_no_e_clock_bit_exp_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    run && is_exp |-> !bus_ctrl_pin_assignment_ff[B_NO_E_CLOCK_BIT]) else $error("no E clock bit set in expanded");
  a_bus_ctrl_pin_assignment_periph_err: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && acc && !ready_ff && is_periph && idx == IDX_BUS_CTRL_PIN_ASSIGNMENT |=> PSLVERR && PREADY)
    else $error("assignment reachable in peripheral mode");
  a_ab_hidden_exp: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && acc && !ready_ff && !is_single && idx == IDX_B_DIR |=> PSLVERR)
    else $error("port B direction visible in expanded");
  a_normal_once_only: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && wr && idx == IDX_BUS_CTRL_PIN_ASSIGNMENT && !is_special && bus_ctrl_pin_assignment_seen_ff |=>
    $stable(bus_ctrl_pin_assignment_ff[B_READ_WRITE_ENABLE]) && $stable(bus_ctrl_pin_assignment_ff[B_PIPE_OUTPUT_ENABLE]))
    else $error("second normal write took effect");
  a_bus_phase_clock_pin_single_rule: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && is_single && bus_ctrl_pin_assignment_ff[B_NO_E_CLOCK_BIT] && !e_dir_ff[4] |=> !PE_OE[4])
    else $error("E clock driven while disabled");
  a_ready_one_cycle: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CORE_CE && PREADY |=> !PREADY) else $error("ready held too long");
  c_bus_ctrl_pin_assignment_write: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr && idx == IDX_BUS_CTRL_PIN_ASSIGNMENT && PSTRB[1]);
  c_periph_err: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
    done && slverr_ff && is_periph);
  c_bus_phase_clock_pin_on: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
    is_single && e_alt[4]);
endmodule

// [bench/pabe_pins.sv]
// Pad model for the three ports: resolves each pin from the block and the outside world.
// Assumes the bench supplies what outside devices drive onto pins the block leaves free.
`timescale 1ns/10ps
module pabe_pins (
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pe_out,
  input wire logic [7:0] pe_oe,
  input wire logic [7:0] pe_pull,
  input wire logic [7:0] pa_ext,
  input wire logic [7:0] pb_ext,
  input wire logic [7:0] pe_ext,
  input wire logic tag_low_n,
  output logic [7:0] pa_pin,
  output logic [7:0] pb_pin,
  output logic [7:0] pe_pin
);
  // The block wins where it drives; elsewhere the outside level, lifted by any pull-up.
  always_comb begin
    pa_pin = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_ext);
    pe_pin = (pe_oe & pe_out) | (~pe_oe & (pe_ext | pe_pull));
    // An outside debugger tags a low byte by pulling pin 3 low while it is free.
    if (!pe_oe[3] && !tag_low_n) begin
      pe_pin[3] = 1'b0;
    end
  end
endmodule

// [bench/tb.sv]
// Self-checking bench for the port block, one task per operating-mode scenario.
// Assumes the pad model in pabe_pins and a 25 MHz core clock.
`timescale 1ns/10ps
module tb;
  import pabe_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h1;
  logic [2:0] op_mode = 3'h4;
  logic [15:0] bus_addr = 16'ha55a;
  logic bus_addr_phase = 1'b0;
  logic bus_data_oe = 1'b0;
  logic phclk = 1'b1;
  logic rw = 1'b1;
  logic lbs_n = 1'b0;
  logic dben_n = 1'b0;
  logic [1:0] qpipe = 2'h2;
  logic pull_en = 1'b0;
  logic [7:0] pa_ext = 8'h3c;
  logic [7:0] pb_ext = 8'h66;
  logic [7:0] pe_ext = 8'h00;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic [15:0] bus_rdata;
  logic tag_lo_n, irq_lvl, nmi_lvl;
  logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pe_out, pe_oe, pe_pull, pa_pin, pb_pin, pe_pin;
  int failures = 0;
  int checks_done = 0;

  // Core clock, 40 ns period.
  always #20 clk = ~clk;

  pabe_top u_pabe_top (.CORE_CLK(clk), .ARST_N(arst_n), .CORE_CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .OP_MODE(op_mode),
    .BUS_ADDR(bus_addr), .BUS_WDATA(16'h1234), .BUS_ADDR_PHASE(bus_addr_phase),
    .BUS_DATA_OE(bus_data_oe), .BUS_PHASE_CLK(phclk), .BUS_RW(rw),
    .LOW_BYTE_STROBE_N(lbs_n), .DATA_BUS_ENABLE_N(dben_n), .QUEUE_PIPE(qpipe),
    .PULL_EN_E(pull_en), .BUS_RDATA(bus_rdata), .TAG_LOW_INPUT_N(tag_lo_n),
    .IRQ_N_LVL(irq_lvl), .NONMASKABLE_INTERRUPT_PIN_N(nmi_lvl), .PA_IN(pa_pin),
    .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_pin), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PE_IN(pe_pin), .PE_OUT(pe_out), .PE_OE(pe_oe), .PE_PULL(pe_pull));

  pabe_pins u_pabe_pins (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .pe_out(pe_out), .pe_oe(pe_oe), .pe_pull(pe_pull), .pa_ext(pa_ext), .pb_ext(pb_ext),
    .pe_ext(pe_ext), .tag_low_n(1'b1), .pa_pin(pa_pin), .pb_pin(pb_pin), .pe_pin(pe_pin));

  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One comparison; a mismatch is reported at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
           input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {6'h00, idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    // A slave that never answers counts as a mismatch and closes the run.
    if (n >= 40) begin
      failures++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Byte write to one register, expected to be accepted.
  task wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, 4'h1, rd, err);
    chk({31'h0, err}, 32'h0);
  endtask

  // Read one register and compare data and error flag.
  task rdchk(input logic [3:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0, 4'h1, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  // Reset with a given strap; the block needs three edges after release before it answers.
  task do_reset(input logic [2:0] m);
    arst_n <= 1'b0;
    op_mode <= m;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // Normal single-chip: general-purpose ports, write-once assignment bits, E clock gating.
  task single_chip;
    logic [31:0] rd;
    logic err;
    do_reset(OPM_NORM_SINGLE);
    rdchk(IDX_A_DIR, 32'h0, 1'b0);
    rdchk(IDX_B_DIR, 32'h0, 1'b0);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h90, 1'b0);
    pull_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pe_oe, 8'h00);
    chk(pe_pull, 8'h8f);
    wr(IDX_A_DIR, 32'hf0);
    wr(IDX_A_DATA, 32'h5a);
    wr(IDX_B_DIR, 32'h0f);
    wr(IDX_B_DATA, 32'ha5);
    repeat (4) @(posedge clk);
    chk(pa_oe, 8'hf0);
    chk(pb_oe, 8'h0f);
    rdchk(IDX_A_DATA, 32'h5c, 1'b0);
    rdchk(IDX_B_DATA, 32'h65, 1'b0);
    // Assignment and mode in one 16-bit write; stretch on without visibility frees pin 4.
    apb(1'b1, IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h01ac, 4'h3, rd, err);
    chk({31'h0, err}, 32'h0);
    rdchk(IDX_MODE, 32'h01, 1'b0);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h01ac, 1'b0);
    repeat (3) @(posedge clk);
    chk(pe_oe, 8'h00);
    // Second write: only the data-enable bit may still change.
    wr(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h00);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h012c, 1'b0);
    wr(IDX_E_DIR, 32'hff);
    rdchk(IDX_E_DIR, 32'hfc, 1'b0);
    repeat (3) @(posedge clk);
    chk(pe_oe & 8'h7f, 8'h7c);
    chk(pe_pull & 8'h0f, 8'h03);
  endtask

  // Peripheral: expansion registers and the assignment register are hidden.
  task peripheral;
    do_reset(OPM_PERIPH);
    rdchk(IDX_A_DIR, 32'h0, 1'b1);
    rdchk(IDX_B_DATA, 32'h0, 1'b1);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h0, 1'b1);
    rdchk(IDX_E_DATA, 32'h0, 1'b1);
    rdchk(4'h5, 32'h0, 1'b1);
  endtask

  // Special expanded wide: bus-control alternates, address pins, emulation hiding port E.
  task special_wide;
    do_reset(OPM_SPEC_WIDE);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h2c, 1'b0);
    rdchk(IDX_A_DIR, 32'h0, 1'b1);
    bus_addr_phase <= 1'b1;
    pull_en <= 1'b0;
    pe_ext <= 8'h01;
    repeat (5) @(posedge clk);
    chk(bus_rdata, 16'ha55a);
    chk({irq_lvl, nmi_lvl}, 2'b01);
    chk(tag_lo_n, 1'b0);
    chk(pe_oe & 8'hfc, 8'hfc);
    chk(pe_out & 8'hfc, 8'h54);
    chk(pa_out, 8'ha5);
    chk(pb_out, 8'h5a);
    chk(pb_oe, 8'hff);
    // First write in a special mode is ignored by the write-once bits.
    wr(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h80);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'hac, 1'b0);
    wr(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h10);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h00, 1'b0);
    rdchk(IDX_E_DIR, 32'h0, 1'b0);
    wr(IDX_MODE, 32'h02);
    rdchk(IDX_E_DIR, 32'h0, 1'b1);
  endtask

  // Normal expanded narrow: port B keeps the address, the strobe pin stays free.
  task normal_narrow;
    do_reset(OPM_NORM_NARROW);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h0, 1'b0);
    wr(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h1c);
    rdchk(IDX_BUS_CTRL_PIN_ASSIGNMENT, 32'h0c, 1'b0);
    bus_addr_phase <= 1'b0;
    bus_data_oe <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pe_oe, 8'h94);
    chk(pa_out, 8'h12);
    chk(pa_oe, 8'hff);
    chk(pb_out, 8'h5a);
    chk(pb_oe, 8'hff);
  endtask

  initial begin
    single_chip();
    peripheral();
    special_wide();
    normal_narrow();
    results();
  end
endmodule
